/* ola_pkg.sv */
// Constants, register map and state type of the optical level
// autocalibrator. Assumes a single 100 MHz clock domain.
package ola_pkg;

    // ----------------------------------------------------------------
    // Widths and timing
    // ----------------------------------------------------------------
    localparam int          DRV_W_DEF     = 8;
    localparam int          SIG_W_DEF     = 10;
    localparam logic [7:0]  DRV_MAX_RST   = 8'hFF;
    localparam int          CLK_MHZ       = 100;
    localparam int          DEB_TIME_US   = 10;
    localparam int          DEB_CYC       = DEB_TIME_US * CLK_MHZ;
    localparam int          RAMP_TIME_US  = 100;
    localparam int          RAMP_CYC      = RAMP_TIME_US * CLK_MHZ;
    localparam int          BLINK_TIME_MS = 250;
    localparam int          BLINK_CYC     = BLINK_TIME_MS * 1000 * CLK_MHZ;
    localparam int          THR_HI_NUM    = 2;
    localparam int          THR_LO_NUM    = 1;
    localparam int          THR_DEN       = 3;
    localparam logic        CAL_OUT_LVL   = 1'b1;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_DRIVE     = 8'h08;
    localparam logic [7:0]  REG_LIMIT     = 8'h0C;
    localparam logic [7:0]  REG_CAL_SIG   = 8'h10;
    localparam int          CTRL_START    = 0;
    localparam int          ST_BUSY_BIT   = 0;
    localparam int          ST_LOCK_BIT   = 1;
    localparam int          ST_FAIL_BIT   = 2;
    localparam int          ST_HIT_BIT    = 3;

    typedef enum logic [2:0] {
        ST_LOAD,
        ST_IDLE,
        ST_RAMP,
        ST_LOCK,
        ST_FAIL
    } ola_state_e;

endpackage

/* ola_if.sv */
// Carrier between the top and the recalibrate input filter.
// Assumes both ends run on the same clock.
interface ola_if;
    logic raw_n;
    logic req;
    modport filt (input raw_n, output req);
    modport user (output raw_n, input req);
endinterface

/* ola_recal_filter.sv */
// Synchroniser and debouncer for the active-low recalibrate pin.
// Assumes the pin idles high; one request per held low level.
module ola_recal_filter
    import ola_pkg::*;
#(
    parameter int CYC = DEB_CYC
)(
    input  wire logic clk,
    input  wire logic rst_n,
    ola_if.filt       port
);
    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(CYC - 1);

    logic          sync1_q;
    logic          sync2_q;
    logic [CW-1:0] cnt_q;
    logic          fired_q;
    logic          req_q;
    logic          done;

    assign done     = ~sync2_q & ~fired_q & (cnt_q == LAST);
    assign port.req = req_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            cnt_q   <= '0;
            fired_q <= 1'b0;
            req_q   <= 1'b0;
        end
        else
        begin
            sync1_q <= port.raw_n;
            sync2_q <= sync1_q;
            req_q   <= done;
            if (sync2_q)
            begin
                cnt_q   <= '0;
                fired_q <= 1'b0;
            end
            else if (done)
                fired_q <= 1'b1;
            else if (!fired_q)
                cnt_q <= cnt_q + CW'(1);
        end
    end
endmodule

/* ola_top.sv */
// Calibration controller: LED drive ramp, lock, nonvolatile keep,
// lamps and threshold outputs. Assumes an external comparator for
// the calibration level, a sampled optical signal and a small
// nonvolatile store that presents its word once after power-up.
module ola_top
    import ola_pkg::*;
#(
    parameter int DRV_W     = DRV_W_DEF,
    parameter int SIG_W     = SIG_W_DEF,
    parameter int RAMP_CYCS = RAMP_CYC,
    parameter int BLINK_CYCS = BLINK_CYC
)(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             recal_n,
    input  wire logic             level_hit,
    input  wire logic [SIG_W-1:0] sig_level,
    input  wire logic             nv_load_valid,
    input  wire logic [DRV_W:0]   nv_load_word,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata_q,
    output logic      [DRV_W-1:0] led_drive_q,
    output logic                  green_q,
    output logic                  red_q,
    output logic                  blue_q,
    output logic                  logic_a_q,
    output logic                  logic_b_q,
    output logic                  nv_store_q,
    output logic      [DRV_W:0]   nv_word_q
);
    // ----------------------------------------------------------------
    // Constants derived from widths
    // ----------------------------------------------------------------
    localparam int RW = $clog2(RAMP_CYCS + 1);
    localparam int BW = $clog2(BLINK_CYCS + 1);
    localparam int FULL = (1 << SIG_W) - 1;
    localparam logic [SIG_W-1:0] THR_HI =
        SIG_W'((FULL * THR_HI_NUM) / THR_DEN);
    localparam logic [SIG_W-1:0] THR_LO =
        SIG_W'((FULL * THR_LO_NUM) / THR_DEN);
    localparam logic [RW-1:0] RAMP_LAST = RW'(RAMP_CYCS - 1);
    localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCS - 1);

    // ----------------------------------------------------------------
    // Recalibrate input filter
    // ----------------------------------------------------------------
    ola_if recal_if ();
    assign recal_if.raw_n = recal_n;

    ola_recal_filter #(
        .CYC (DEB_CYC)
    ) u_filter (
        .clk   (clk),
        .rst_n (rst_n),
        .port  (recal_if.filt)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ola_state_e       state_q;
    logic [RW-1:0]    ramp_cnt_q;
    logic [BW-1:0]    blink_cnt_q;
    logic             blink_q;
    logic [DRV_W-1:0] limit_q;
    logic [SIG_W-1:0] cal_sig_q;
    logic             sw_start_q;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire start      = recal_if.req | sw_start_q;
    wire ramp_tick  = (state_q == ST_RAMP) &&
                      (ramp_cnt_q == RAMP_LAST);
    wire at_limit   = (led_drive_q >= limit_q);
    wire do_lock    = ramp_tick & level_hit;
    wire do_fail    = ramp_tick & ~level_hit & at_limit;
    wire do_step    = ramp_tick & ~level_hit & ~at_limit;
    wire busy       = (state_q == ST_RAMP);
    wire locked     = (state_q == ST_LOCK);
    wire failed     = (state_q == ST_FAIL);
    wire sig_hi     = sig_level > THR_HI;
    wire sig_lo     = sig_level < THR_LO;
    wire wr_ctrl    = reg_wr && (reg_addr == REG_CTRL);
    wire wr_limit   = reg_wr && (reg_addr == REG_LIMIT);
    wire nv_has_cal = nv_load_word[DRV_W];

    logic [3:0] status_w;
    assign status_w[ST_BUSY_BIT] = busy;
    assign status_w[ST_LOCK_BIT] = locked;
    assign status_w[ST_FAIL_BIT] = failed;
    assign status_w[ST_HIT_BIT]  = level_hit;

    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (reg_addr)
            REG_STATUS:  rd_mux = {28'h0000000, status_w};
            REG_DRIVE:   rd_mux = 32'(led_drive_q);
            REG_LIMIT:   rd_mux = 32'(limit_q);
            REG_CAL_SIG: rd_mux = 32'(cal_sig_q);
            default:     rd_mux = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // Calibration sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q     <= ST_LOAD;
            led_drive_q <= '0;
            cal_sig_q   <= '0;
        end
        else if (start)
        begin
            // A new request restarts from zero drive in any state
            state_q     <= ST_RAMP;
            led_drive_q <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_LOAD:
                    if (nv_load_valid)
                    begin
                        // Resume with stored drive if flagged, else idle at zero; no new ramp
                        state_q     <= nv_has_cal ? ST_LOCK : ST_IDLE;
                        led_drive_q <= nv_has_cal ?
                            nv_load_word[DRV_W-1:0] : '0;
                    end
                ST_RAMP:
                    if (do_lock)
                    begin
                        state_q   <= ST_LOCK;
                        cal_sig_q <= sig_level;
                    end
                    else if (do_fail)
                        state_q <= ST_FAIL;
                    else if (do_step)
                        led_drive_q <= led_drive_q + DRV_W'(1);
                ST_IDLE, ST_LOCK, ST_FAIL:
                    state_q <= state_q;
            endcase
        end
    end

    // Interval counter: the sequencer reads the comparator only at its end so the
    // optical path has settled on the latest step.
    always_ff @(posedge clk)
    begin
        if (!rst_n || start || ramp_tick)
            ramp_cnt_q <= '0;
        else if (busy)
            ramp_cnt_q <= ramp_cnt_q + RW'(1);
    end

    // ----------------------------------------------------------------
    // Nonvolatile store
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            nv_store_q <= 1'b0;
            nv_word_q  <= '0;
        end
        else
        begin
            nv_store_q <= do_lock & ~start;
            if (do_lock && !start)
                nv_word_q <= {1'b1, led_drive_q};
        end
    end

    // ----------------------------------------------------------------
    // Lamps
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n || blink_cnt_q == BLINK_LAST)
            blink_cnt_q <= '0;
        else
            blink_cnt_q <= blink_cnt_q + BW'(1);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            blink_q <= 1'b0;
            green_q <= 1'b0;
            red_q   <= 1'b0;
            blue_q  <= 1'b0;
        end
        else
        begin
            if (blink_cnt_q == BLINK_LAST)
                blink_q <= ~blink_q;
            green_q <= busy ? blink_q :
                       locked & (sig_level < cal_sig_q);
            red_q   <= failed;
            blue_q  <= locked & (sig_level > cal_sig_q);
        end
    end

    // ----------------------------------------------------------------
    // Threshold outputs
    // ----------------------------------------------------------------
    // While locked, outputs hold between the two thresholds, giving hysteresis.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            logic_a_q <= 1'b0;
            logic_b_q <= 1'b0;
        end
        else if (!locked)
        begin
            logic_a_q <= 1'b0;
            logic_b_q <= (do_lock & ~start) ? CAL_OUT_LVL : 1'b0;
        end
        else
        begin
            if (sig_hi)
                logic_a_q <= 1'b1;
            else if (sig_lo)
                logic_a_q <= 1'b0;
            if (sig_lo)
                logic_b_q <= 1'b0;
            else if (sig_hi)
                logic_b_q <= CAL_OUT_LVL;
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            limit_q     <= DRV_W'(DRV_MAX_RST);
            sw_start_q  <= 1'b0;
            reg_rdata_q <= 32'h00000000;
        end
        else
        begin
            sw_start_q  <= wr_ctrl & reg_wdata[CTRL_START];
            reg_rdata_q <= reg_rd ? rd_mux : 32'h00000000;
            if (wr_limit)
                limit_q <= reg_wdata[DRV_W-1:0];
        end
    end
endmodule

/* ola_top_asserts.sv */
// Port-level checks for the autocalibrator top.
// Assumes one clock domain and a synchronous active-low reset.
module ola_top_asserts #(
    parameter int DRV_W = 8,
    parameter int SIG_W = 10
)(
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic [SIG_W-1:0] sig_level,
    input wire logic             reg_rd,
    input wire logic             nv_load_valid,
    input wire logic [31:0]      reg_rdata_q,
    input wire logic [DRV_W-1:0] led_drive_q,
    input wire logic             green_q,
    input wire logic             red_q,
    input wire logic             blue_q,
    input wire logic             logic_a_q,
    input wire logic             logic_b_q,
    input wire logic             nv_store_q,
    input wire logic [DRV_W:0]   nv_word_q
);
    localparam int FS = (1 << SIG_W) - 1;
    localparam int HI = FS * 2 / 3;
    localparam int LO = FS / 3;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------
    // Drive ramp and lock
    // ----------------------------
    sequence s_frozen;
        $stable(led_drive_q) [*8];
    endsequence
    a_drive_step: assert property (
        led_drive_q != $past(led_drive_q) |-> $past(nv_load_valid) ||
        led_drive_q == $past(led_drive_q) + 1'h1 || led_drive_q == '0)
        else $error("drive jumped by more than one step");
    a_drive_frozen: assert property (
        nv_store_q |=> s_frozen)
        else $error("drive moved after lock");
    a_store_word: assert property (
        nv_store_q |-> nv_word_q == {1'h1, led_drive_q})
        else $error("stored word differs from locked drive");
    a_store_pulse: assert property (
        nv_store_q |=> !nv_store_q)
        else $error("store pulse longer than one cycle");
    a_fail_hold: assert property (
        $rose(red_q) |-> $stable(led_drive_q) && !logic_b_q)
        else $error("fail lamp without held drive");
    // ----------------------------
    // Outputs and lamps
    // ----------------------------
    a_a_rises: assert property (
        $rose(logic_a_q) |-> $past(sig_level) > HI)
        else $error("output A set below upper threshold");
    a_b_falls: assert property (
        $fell(logic_b_q) |-> $past(sig_level) < LO || led_drive_q == '0)
        else $error("output B cleared above lower threshold");
    a_lamp_excl: assert property (
        !(blue_q && green_q) && !(red_q && blue_q))
        else $error("conflicting lamps lit");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata_q == '0)
        else $error("read data outside read cycle");
endmodule

bind ola_top ola_top_asserts #(.DRV_W(DRV_W), .SIG_W(SIG_W)) u_chk (
    .clk, .rst_n, .sig_level, .reg_rd, .nv_load_valid, .reg_rdata_q,
    .led_drive_q, .green_q, .red_q, .blue_q, .logic_a_q, .logic_b_q,
    .nv_store_q, .nv_word_q
);

/* ola_optic_model.sv */
// Far side: LED/phototransistor comparator and nonvolatile store.
// Assumes the store keeps its word across the block's resets.
module ola_optic_model (
    input  wire logic       clk,
    input  wire logic [7:0] led_drive,
    input  wire logic [7:0] hit_code,
    input  wire logic       nv_store,
    input  wire logic [8:0] nv_word,
    input  wire logic       load_go,
    output logic            level_hit,
    output logic            nv_load_valid,
    output logic [8:0]      nv_load_word
);
    timeunit 1ns;
    timeprecision 1ns;
    // Blank store at power-up: flag clear
    logic [8:0] nv_mem_q = 9'h000;
    // ----------------------------
    // Behaviour
    // ----------------------------
    assign level_hit = led_drive >= hit_code;
    always_ff @(posedge clk)
    begin
        if (nv_store)
            nv_mem_q <= nv_word;
    end
    // Word is only valid with the strobe; inverted otherwise
    assign nv_load_valid = load_go;
    assign nv_load_word = load_go ? nv_mem_q : ~nv_mem_q;
endmodule

/* testbench.sv */
// Self-checking bench for the autocalibrator top.
// Assumes the comparator/store model on the far side.
module testbench
    import ola_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        recal_n = 1;
    logic [9:0]  sig_level = 10'h200;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 0;
    logic        reg_rd = 0;
    logic [7:0]  hit_code = 8'h05;
    logic        load_go = 0;
    logic        level_hit, nv_load_valid, nv_store_q, green_q, red_q;
    logic        blue_q, logic_a_q, logic_b_q;
    logic [8:0]  nv_load_word, nv_word_q;
    logic [7:0]  led_drive_q;
    logic [31:0] reg_rdata_q;
    logic [9:0]  sv [5] = '{10'h2BC, 10'h1F4, 10'h12C, 10'h1F4, 10'h2BC};
    logic [3:0]  ev [5] = '{4'hE, 4'hD, 4'h1, 4'h1, 4'hE};
    int          fails = 0;
    int          samples_checked = 0;
    int          tg;
    // Short ramp and blink so a calibration takes tens of cycles
    ola_top #(.RAMP_CYCS(8), .BLINK_CYCS(4)) u_dut (
        .clk, .rst_n, .recal_n, .level_hit, .sig_level, .nv_load_valid,
        .nv_load_word, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata_q, .led_drive_q, .green_q, .red_q, .blue_q,
        .logic_a_q, .logic_b_q, .nv_store_q, .nv_word_q
    );
    ola_optic_model u_far (
        .clk, .led_drive(led_drive_q), .hit_code, .nv_store(nv_store_q),
        .nv_word(nv_word_q), .load_go, .level_hit, .nv_load_valid,
        .nv_load_word
    );
    // ----------------------------
    // Tasks
    // ----------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata_q, e);
    endtask
    task automatic nv_load();
        @(posedge clk);
        load_go <= 1'h1;
        @(posedge clk);
        load_go <= 1'h0;
    endtask
    task automatic wait_on(input logic red);
        logic g;
        int   i;
        tg = 0;
        g = green_q;
        for (i = 0; i < 4000; i++)
        begin
            tick(1);
            if (green_q !== g)
                tg++;
            g = green_q;
            if ((red ? red_q : nv_store_q) === 1'h1)
                break;
        end
        if (i == 4000)
        begin
            fails++;
            test_done();
        end
    endtask
    task automatic hold(input int n);
        logic [8:0] s;
        // Step off the launching edge before taking the reference
        #1;
        s = {green_q, led_drive_q};
        repeat (n)
        begin
            tick(1);
            chk(32'({green_q, led_drive_q}), 32'(s));
        end
    endtask
    // ----------------------------
    // Sequence
    // ----------------------------
    initial
    begin
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        tick(1);
        chk(32'({nv_store_q, red_q, blue_q, logic_b_q, led_drive_q}),
            32'h0);
        nv_load();
        rd(REG_STATUS, 32'h0);
        rd(REG_LIMIT, 32'hFF);
        rd(8'h14, 32'h0);
        @(posedge clk);
        recal_n <= 1'h0;
        repeat (500) @(posedge clk);
        recal_n <= 1'h1;
        tick(1100);
        rd(REG_STATUS, 32'h0);
        @(posedge clk);
        recal_n <= 1'h0;
        wait_on(1'h0);
        chk(32'(tg > 2), 32'h1);
        chk(32'(led_drive_q), 32'h5);
        chk(32'(nv_word_q), 32'h00000105);
        chk(32'(logic_b_q), 32'(CAL_OUT_LVL));
        @(posedge clk);
        recal_n <= 1'h1;
        hit_code <= 8'h00;
        hold(40);
        rd(REG_CAL_SIG, 32'h200);
        rd(REG_STATUS, 32'hA);
        rd(REG_DRIVE, 32'h5);
        foreach (sv[k])
        begin
            @(posedge clk);
            sig_level <= sv[k];
            tick(3);
            chk(32'({logic_a_q, logic_b_q, blue_q, green_q}),
                32'(ev[k]));
        end
        // Restart from the locked state, then run into the limit
        wr(REG_LIMIT, 32'h3);
        hit_code <= 8'hC8;
        wr(REG_CTRL, 32'h1);
        tick(1);
        chk(32'(led_drive_q), 32'h0);
        wait_on(1'h1);
        chk(32'(led_drive_q), 32'h3);
        rd(REG_STATUS, 32'h4);
        rd(REG_LIMIT, 32'h3);
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        nv_load();
        tick(2);
        chk(32'(led_drive_q), 32'h5);
        rd(REG_STATUS, 32'h2);
        hold(20);
        test_done();
    end
endmodule
